// ===== hdl/mhbp_pkg.sv
// Shared constants and types of the muxed host bus port
package mhbp_pkg;
    localparam int MHBP_ADDR_W = 10;
    localparam int MHBP_DATA_W = 8;

    // Layout of the synchronised pin vector
    localparam int MHBP_POS_DATA = 0;
    localparam int MHBP_POS_ADDR = 8;
    localparam int MHBP_POS_ALE = 18;
    localparam int MHBP_POS_DIR = 19;
    localparam int MHBP_POS_STROBE = 20;
    localparam int MHBP_POS_CS_N = 21;
    localparam int MHBP_POS_STYLE = 22;
    localparam int MHBP_POS_IM = 23;
    localparam int MHBP_SYNC_W = 24;

    // Chip select and write direction reset inactive (high)
    localparam logic [MHBP_SYNC_W-1:0] MHBP_SYNC_RST = 24'h280000;

    localparam logic [MHBP_ADDR_W-1:0] MHBP_ADDR_RST = 10'h000;
    localparam logic [MHBP_DATA_W-1:0] MHBP_DATA_RST = 8'h00;

    typedef enum logic [1:0] {
        MHBP_IDLE = 2'b00,
        MHBP_WAIT = 2'b01,
        MHBP_DONE = 2'b10
    } mhbp_state_t;
endpackage

// ===== hdl/mhbp_sync_if.sv
// Synchronised host pin levels passed from the synchroniser to the port logic
interface mhbp_sync_if;
    import mhbp_pkg::*;
    logic im;
    logic style;
    logic cs_n;
    logic strobe;
    logic dir;
    logic ale;
    logic [MHBP_ADDR_W-1:0] addr;
    logic [MHBP_DATA_W-1:0] data;
    modport src (output im, style, cs_n, strobe, dir, ale, addr, data);
    modport dst (input im, style, cs_n, strobe, dir, ale, addr, data);
endinterface

// ===== hdl/mhbp_sync.sv
// Two-stage synchroniser for all asynchronous host port pins
module mhbp_sync
    import mhbp_pkg::*;
#(
    parameter int W = MHBP_SYNC_W,
    parameter logic [W-1:0] RST_VAL = MHBP_SYNC_RST
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] raw_i,
    mhbp_sync_if.src sif
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } mhbp_sync_regs_t;

    mhbp_sync_regs_t r_reg;
    mhbp_sync_regs_t r_next;

    always_comb begin
        r_next.meta = raw_i;
        r_next.sync = r_reg.meta;
    end

    // Constant reset keeps chip select inactive until real levels arrive
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg <= {RST_VAL, RST_VAL};
        end else begin
            r_reg <= r_next;
        end
    end

    assign sif.data = r_reg.sync[MHBP_POS_DATA +: MHBP_DATA_W];
    assign sif.addr = r_reg.sync[MHBP_POS_ADDR +: MHBP_ADDR_W];
    assign sif.ale = r_reg.sync[MHBP_POS_ALE];
    assign sif.dir = r_reg.sync[MHBP_POS_DIR];
    assign sif.strobe = r_reg.sync[MHBP_POS_STROBE];
    assign sif.cs_n = r_reg.sync[MHBP_POS_CS_N];
    assign sif.style = r_reg.sync[MHBP_POS_STYLE];
    assign sif.im = r_reg.sync[MHBP_POS_IM];
endmodule

// ===== hdl/mhbp_top.sv
// Host microprocessor port: strobe decode, address latch, acknowledge and interrupt
module mhbp_top
    import mhbp_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic BUS_STYLE_SELECT_I,
    input wire logic STROBE_STYLE_I,
    input wire logic [MHBP_ADDR_W-1:0] ADDR_LINES_I,
    input wire logic SHARED_ACCESS_STROBE_I,
    input wire logic RW_DIR_I,
    input wire logic CHIP_SELECT_N_I,
    input wire logic ADDRESS_LATCH_STROBE_I,
    input wire logic [MHBP_DATA_W-1:0] SHARED_DATA_LINES_I,
    output logic [MHBP_DATA_W-1:0] SHARED_DATA_LINES_O,
    output logic SHARED_DATA_LINES_OE_O,
    output logic TRANSFER_DONE_N_O,
    output logic TRANSFER_DONE_N_OE_O,
    output logic INTERRUPT_REQUEST_N_O,
    output logic INTERRUPT_REQUEST_N_OE_O,
    output logic [MHBP_ADDR_W-1:0] MEM_ADDR_O,
    output logic [MHBP_DATA_W-1:0] MEM_WDATA_O,
    output logic MEM_WR_O,
    output logic MEM_RD_O,
    input wire logic [MHBP_DATA_W-1:0] MEM_RDATA_I,
    input wire logic MEM_RDATA_VALID_I,
    input wire logic [MHBP_DATA_W-1:0] IRQ_STATUS_I,
    input wire logic [MHBP_DATA_W-1:0] IRQ_ENABLE_I
);
    typedef struct packed {
        mhbp_state_t state;
        logic [MHBP_ADDR_W-1:0] mux_addr;
        logic [MHBP_ADDR_W-1:0] mem_addr;
        logic [MHBP_DATA_W-1:0] wdata;
        logic [MHBP_DATA_W-1:0] rdata;
        logic wr;
        logic rd;
        logic is_read;
        logic irq;
    } mhbp_regs_t;

    mhbp_regs_t r_reg;
    mhbp_regs_t r_next;

    mhbp_sync_if sif ();

    mhbp_sync #(
        .W(MHBP_SYNC_W),
        .RST_VAL(MHBP_SYNC_RST)
    ) u_sync (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .raw_i({BUS_STYLE_SELECT_I, STROBE_STYLE_I, CHIP_SELECT_N_I,
                SHARED_ACCESS_STROBE_I, RW_DIR_I, ADDRESS_LATCH_STROBE_I,
                ADDR_LINES_I, SHARED_DATA_LINES_I}),
        .sif(sif)
    );

    logic muxed;
    logic rw_strobes;
    logic data_strobe_on;
    logic rd_on;
    logic wr_on;
    logic access_active;
    logic access_read;
    logic [MHBP_ADDR_W-1:0] access_addr;

    always_comb begin
        muxed = sif.im;
        // Non-multiplexed bus has only the strobe-style variant
        rw_strobes = sif.im & ~sif.style;
        data_strobe_on = muxed ? sif.strobe : ~sif.strobe;
        rd_on = ~sif.strobe;
        wr_on = ~sif.dir;
        if (rw_strobes) begin
            access_active = ~sif.cs_n & (rd_on | wr_on);
            access_read = rd_on;
        end else begin
            access_active = ~sif.cs_n & data_strobe_on;
            access_read = sif.dir;
        end
        access_addr = muxed ? r_reg.mux_addr : sif.addr;
    end

    always_comb begin
        r_next = r_reg;
        r_next.wr = 1'b0;
        r_next.rd = 1'b0;
        r_next.irq = |(IRQ_STATUS_I & IRQ_ENABLE_I);
        // In muxed mode the latch stays transparent while enable is high, holds after it falls
        if (sif.im && sif.ale) begin
            r_next.mux_addr = {{(MHBP_ADDR_W-MHBP_DATA_W){1'b0}}, sif.data};
        end
        case (r_reg.state)
            MHBP_IDLE: begin
                if (access_active) begin
                    r_next.mem_addr = access_addr;
                    r_next.is_read = access_read;
                    if (access_read) begin
                        r_next.rd = 1'b1;
                        r_next.state = MHBP_WAIT;
                    end else begin
                        r_next.wr = 1'b1;
                        r_next.wdata = sif.data;
                        r_next.state = MHBP_DONE;
                    end
                end
            end
            MHBP_WAIT: begin
                // Host may abandon the cycle; drop it rather than drive late
                if (!access_active) begin
                    r_next.state = MHBP_IDLE;
                end else if (MEM_RDATA_VALID_I) begin
                    r_next.rdata = MEM_RDATA_I;
                    r_next.state = MHBP_DONE;
                end
            end
            MHBP_DONE: begin
                if (!access_active) begin
                    r_next.state = MHBP_IDLE;
                end
            end
            default: begin
                r_next.state = MHBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            r_reg.state <= MHBP_IDLE;
            r_reg.mux_addr <= MHBP_ADDR_RST;
            r_reg.mem_addr <= MHBP_ADDR_RST;
            r_reg.wdata <= MHBP_DATA_RST;
            r_reg.rdata <= MHBP_DATA_RST;
            r_reg.wr <= 1'b0;
            r_reg.rd <= 1'b0;
            r_reg.is_read <= 1'b0;
            r_reg.irq <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign SHARED_DATA_LINES_O = r_reg.rdata;
    // Drive only while the read cycle that fetched the data is still open
    assign SHARED_DATA_LINES_OE_O = (r_reg.state == MHBP_DONE) && r_reg.is_read &&
                                    access_active && access_read;
    assign TRANSFER_DONE_N_O = 1'b0;
    assign TRANSFER_DONE_N_OE_O = (r_reg.state == MHBP_DONE) && access_active;
    assign INTERRUPT_REQUEST_N_O = 1'b0;
    assign INTERRUPT_REQUEST_N_OE_O = r_reg.irq;
    assign MEM_ADDR_O = r_reg.mem_addr;
    assign MEM_WDATA_O = r_reg.wdata;
    assign MEM_WR_O = r_reg.wr;
    assign MEM_RD_O = r_reg.rd;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    sequence seq_start;
        r_reg.state == MHBP_IDLE && access_active;
    endsequence

    sequence seq_wr_start;
        seq_start ##0 !access_read;
    endsequence

    sequence seq_rd_fetch;
        r_reg.state == MHBP_WAIT && access_active && MEM_RDATA_VALID_I;
    endsequence

    sequence seq_rd_start;
        seq_start ##0 access_read;
    endsequence

    sequence seq_rd_issued;
        seq_rd_start ##1 MEM_RD_O;
    endsequence

    AST_NONMUX_ADDR: assert property (seq_start ##0 !sif.im |=>
        MEM_ADDR_O == $past(sif.addr))
        else $error("non-multiplexed address not taken from address lines");

    AST_MUX_ADDR: assert property (seq_start ##0 sif.im |=>
        MEM_ADDR_O == $past(r_reg.mux_addr))
        else $error("multiplexed address not taken from latch");

    AST_LATCH_IGNORED: assert property (!sif.im |=> $stable(r_reg.mux_addr))
        else $error("address latch moved in non-multiplexed mode");

    AST_WRITE_SEQ: assert property (seq_wr_start |=>
        MEM_WR_O && !MEM_RD_O && MEM_WDATA_O == $past(sif.data)
        ##1 (TRANSFER_DONE_N_OE_O || !access_active))
        else $error("write not issued or not acknowledged");

    AST_READ_DRIVE: assert property (seq_rd_fetch |=>
        (!access_active || !access_read ||
         (SHARED_DATA_LINES_OE_O && SHARED_DATA_LINES_O == $past(MEM_RDATA_I))))
        else $error("read data not driven after fetch");

    AST_CS_GATES: assert property (sif.cs_n |=> !MEM_WR_O && !MEM_RD_O)
        else $error("memory access without chip select");

    AST_HIZ_IDLE: assert property ((sif.cs_n || !access_read) |->
        !SHARED_DATA_LINES_OE_O)
        else $error("data lines driven outside a read");

    AST_ACK_RELEASE: assert property (!access_active |-> !TRANSFER_DONE_N_OE_O)
        else $error("acknowledge held after access ended");

    AST_IRQ_GATE: assert property (1'b1 |=>
        INTERRUPT_REQUEST_N_OE_O == $past(|(IRQ_STATUS_I & IRQ_ENABLE_I)))
        else $error("interrupt request does not follow enabled status");

    AST_RW_STROBE_WR: assert property (rw_strobes && !sif.dir && sif.strobe |->
        !SHARED_DATA_LINES_OE_O)
        else $error("data lines driven during write strobe");

    // Checks below read the synchronised pins, two cycles behind the device pins
    AST_READ_ISSUE: assert property (seq_rd_start |=>
        MEM_RD_O && !MEM_WR_O && !TRANSFER_DONE_N_OE_O && !SHARED_DATA_LINES_OE_O)
        else $error("read not issued cleanly");

    AST_RD_NO_EARLY_ACK: assert property (seq_rd_issued ##0 !MEM_RDATA_VALID_I |->
        !TRANSFER_DONE_N_OE_O && !SHARED_DATA_LINES_OE_O)
        else $error("acknowledge before read data arrived");

    AST_ACK_READ: assert property (seq_rd_fetch ##1 (access_active && access_read) |->
        TRANSFER_DONE_N_OE_O && SHARED_DATA_LINES_OE_O)
        else $error("read completion not acknowledged with data");

    AST_ACK_STANDS: assert property (TRANSFER_DONE_N_OE_O |=>
        TRANSFER_DONE_N_OE_O || !access_active)
        else $error("acknowledge dropped while access still open");

    AST_WRITE_NO_DRIVE: assert property (seq_wr_start |=>
        !SHARED_DATA_LINES_OE_O ##1 !SHARED_DATA_LINES_OE_O)
        else $error("data lines driven during a write");

    AST_DS_ACCESS: assert property (r_reg.state == MHBP_IDLE && !sif.cs_n &&
        ((sif.im && sif.style && sif.strobe) || (!sif.im && !sif.strobe)) |=>
        MEM_WR_O || MEM_RD_O)
        else $error("data strobe with chip select did not start an access");

    AST_MUX_DS_IDLE: assert property (r_reg.state == MHBP_IDLE &&
        sif.im && sif.style && !sif.strobe |=> !MEM_WR_O && !MEM_RD_O)
        else $error("access started with high-active data strobe low");

    AST_NONMUX_DS_IDLE: assert property (r_reg.state == MHBP_IDLE &&
        !sif.im && sif.strobe |=> !MEM_WR_O && !MEM_RD_O)
        else $error("access started with low-active data strobe high");

    AST_RW_READ: assert property (r_reg.state == MHBP_IDLE &&
        sif.im && !sif.style && !sif.cs_n && !sif.strobe |=> MEM_RD_O && !MEM_WR_O)
        else $error("read strobe did not start a read");

    AST_RW_WRITE: assert property (r_reg.state == MHBP_IDLE &&
        sif.im && !sif.style && !sif.cs_n && sif.strobe && !sif.dir |=>
        MEM_WR_O && !MEM_RD_O && MEM_WDATA_O == $past(sif.data))
        else $error("write strobe did not write the data lines");

    AST_DIR_SELECT: assert property (seq_start ##0 !(sif.im && !sif.style) |=>
        MEM_RD_O == $past(sif.dir) && MEM_WR_O != $past(sif.dir))
        else $error("direction input did not pick read or write");

    AST_STROBE_DIR_WR: assert property (!(sif.im && !sif.style) && !sif.dir |->
        !SHARED_DATA_LINES_OE_O)
        else $error("data lines driven with direction set to write");

    AST_LATCH_FOLLOW: assert property (sif.im && sif.ale |=>
        r_reg.mux_addr[MHBP_DATA_W-1:0] == $past(sif.data))
        else $error("address latch did not follow the data lines");

    AST_WR_PULSE: assert property (MEM_WR_O |=> !MEM_WR_O && !MEM_RD_O)
        else $error("second memory access within one strobe");

    AST_RD_PULSE: assert property (MEM_RD_O |=> !MEM_RD_O && !MEM_WR_O)
        else $error("second memory access within one read");

    AST_RELEASE_IDLE: assert property (r_reg.state == MHBP_DONE && !access_active |=>
        r_reg.state == MHBP_IDLE && !MEM_WR_O && !MEM_RD_O)
        else $error("port did not return to idle after release");

    AST_IRQ_QUIET: assert property (IRQ_ENABLE_I == '0 |=>
        !INTERRUPT_REQUEST_N_OE_O)
        else $error("interrupt request with every source disabled");

    AST_IRQ_RISE: assert property (|(IRQ_STATUS_I & IRQ_ENABLE_I) |=>
        INTERRUPT_REQUEST_N_OE_O)
        else $error("enabled interrupt source not signalled");

    AST_RESET_STATE: assert property (@(posedge CLK_I) disable iff (1'b0)
        !RST_N_I |-> !SHARED_DATA_LINES_OE_O && !TRANSFER_DONE_N_OE_O &&
        !INTERRUPT_REQUEST_N_OE_O && !MEM_WR_O && !MEM_RD_O && MEM_ADDR_O == MHBP_ADDR_RST)
        else $error("port not cleared while reset is held");
endmodule

// ===== dv/mhbp_host_model.sv
// Host processor model driving the shared host port pins
module mhbp_host_model
    import mhbp_pkg::*;
(
    input wire logic clk_i,
    input wire logic ack_oe_i,
    input wire logic data_oe_i,
    input wire logic [MHBP_DATA_W-1:0] data_i,
    output logic im_o,
    output logic style_o,
    output logic [MHBP_ADDR_W-1:0] addr_o,
    output logic strobe_o,
    output logic dir_o,
    output logic cs_n_o,
    output logic ale_o,
    output logic [MHBP_DATA_W-1:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        im_o = 1'b0;
        style_o = 1'b0;
        addr_o = '0;
        strobe_o = 1'b1;
        dir_o = 1'b1;
        cs_n_o = 1'b1;
        ale_o = 1'b0;
        data_o = '0;
    end

    // Mode pins change only between accesses
    task automatic set_mode(input logic muxed, input logic strobe_style);
        im_o <= muxed;
        style_o <= strobe_style;
        // Idle strobe level is the deasserted level of the chosen variant
        strobe_o <= !(muxed && strobe_style);
    endtask

    task automatic access(input logic wr, input logic sel, input logic [9:0] a,
                          input logic [7:0] wd, output logic ok, output logic [8:0] rd);
        int n;
        n = 0;
        @(negedge clk_i);
        addr_o <= im_o ? ~a : a;
        ale_o <= 1'b1;
        data_o <= im_o ? a[7:0] : ~wd;
        repeat (3) @(negedge clk_i);
        ale_o <= 1'b0;
        @(negedge clk_i);
        // Latch left high in non-muxed mode, where it must not matter
        ale_o <= ~im_o;
        data_o <= wr ? wd : ~data_o;
        cs_n_o <= ~sel;
        dir_o <= ~wr;
        strobe_o <= (im_o && !style_o) ? wr : im_o;
        while (!ack_oe_i && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        ok = ack_oe_i;
        rd = {data_oe_i, data_i};
        cs_n_o <= 1'b1;
        strobe_o <= !(im_o && style_o);
        dir_o <= 1'b1;
        ale_o <= 1'b0;
        // Released lines show the inverse, not a stale value
        data_o <= ~data_o;
        repeat (4) @(negedge clk_i);
    endtask
endmodule

// ===== dv/mhbp_top_tb.sv
// Self-checking bench for the muxed host bus port
module mhbp_top_tb
    import mhbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic CLK_I;
    logic RST_N_I;
    logic im, style, strobe, dir, cs_n, ale, mwr, mrd, rvalid, ack_oe, doe, irq_oe;
    logic [9:0] addr, maddr;
    logic [7:0] din, dout, mwdata, rdata, irq_st, irq_en;
    logic ack_n, irq_n, wr, sel, ok;
    logic [9:0] a, ea;
    logic [7:0] wd;
    logic [8:0] rd;
    logic [18:0] notes[$];
    logic [18:0] note;
    integer seed;
    int failures = 0;
    int compares = 0;

    mhbp_top mhbp_top_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .BUS_STYLE_SELECT_I(im),
        .STROBE_STYLE_I(style), .ADDR_LINES_I(addr), .SHARED_ACCESS_STROBE_I(strobe),
        .RW_DIR_I(dir), .CHIP_SELECT_N_I(cs_n), .ADDRESS_LATCH_STROBE_I(ale),
        .SHARED_DATA_LINES_I(din), .SHARED_DATA_LINES_O(dout), .SHARED_DATA_LINES_OE_O(doe),
        .TRANSFER_DONE_N_O(ack_n), .TRANSFER_DONE_N_OE_O(ack_oe),
        .INTERRUPT_REQUEST_N_O(irq_n), .INTERRUPT_REQUEST_N_OE_O(irq_oe),
        .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwdata), .MEM_WR_O(mwr), .MEM_RD_O(mrd),
        .MEM_RDATA_I(rdata), .MEM_RDATA_VALID_I(rvalid), .IRQ_STATUS_I(irq_st),
        .IRQ_ENABLE_I(irq_en));

    mhbp_host_model mhbp_host_model_inst (.clk_i(CLK_I), .ack_oe_i(ack_oe), .data_oe_i(doe),
        .data_i(dout), .im_o(im), .style_o(style), .addr_o(addr), .strobe_o(strobe),
        .dir_o(dir), .cs_n_o(cs_n), .ale_o(ale), .data_o(din));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (failures == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        CLK_I = 1'b0;
        forever #10 CLK_I = ~CLK_I;
    end

    // Memory side answers reads after a random latency
    initial begin
        rvalid = 1'b0;
        rdata = '0;
        forever begin
            // Pulses are read on the falling edge, clear of the edge that launches them
            @(negedge CLK_I);
            if (mrd === 1'b1) begin
                repeat (1 + {$random(seed)} % 4) @(negedge CLK_I);
                rdata <= 8'($random(seed));
                rvalid <= 1'b1;
                @(negedge CLK_I);
                rvalid <= 1'b0;
            end
        end
    end

    always @(negedge CLK_I) begin
        if (mwr === 1'b1 || mrd === 1'b1) begin
            if (notes.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                note = notes.pop_front();
                check({mwr, maddr, note[18] ? mwdata : 8'h00}, note);
            end
        end
    end

    initial begin
        #200000;
        failures++;
        finish_test();
    end

    initial begin
        seed = 32'h6db83124;
        RST_N_I = 1'b0;
        irq_st = '0;
        irq_en = '0;
        repeat (8) @(negedge CLK_I);
        check({doe, ack_oe, irq_oe, mwr, mrd, maddr, mwdata}, 0);
        repeat (8) @(negedge CLK_I);
        RST_N_I = 1'b1;
        for (int m = 0; m < 3; m++) begin
            mhbp_host_model_inst.set_mode(m != 0, m == 1);
            repeat (4) @(negedge CLK_I);
            for (int i = 0; i < 7; i++) begin
                wr = 1'($random(seed));
                a = 10'($random(seed));
                wd = 8'($random(seed));
                sel = (i != 3);
                ea = (m != 0) ? {2'b00, a[7:0]} : a;
                if (sel) notes.push_back({wr, ea, wr ? wd : 8'h00});
                mhbp_host_model_inst.access(wr, sel, a, wd, ok, rd);
                check({ok, ack_n}, {sel, 1'b0});
                if (!wr && sel) check(rd, {1'b1, rdata});
                else check(rd[8], 0);
                check({ack_oe, doe}, 0);
            end
        end
        for (int i = 0; i < 8; i++) begin
            irq_st = 8'($random(seed));
            irq_en = (i == 0) ? 8'h00 : 8'($random(seed));
            repeat (2) @(negedge CLK_I);
            check({irq_oe, irq_n}, {|(irq_st & irq_en), 1'b0});
        end
        check(notes.size(), 0);
        finish_test();
    end
endmodule
